/* File: rtl/l2bf_pkg.sv */
package l2bf_pkg;

  // Destination map layout
  localparam int MAP_W     = 58;
  localparam int ETH_PORTS = 50;  // Gigabit 0..47, ten-gigabit 48..49
  localparam int GE_PORTS  = 48;
  localparam int QUEUES    = 8;
  localparam int QBASE     = 50;  // First supervisor queue bit
  localparam int HI_W      = MAP_W - 32;
  localparam int RXHI_W    = ETH_PORTS - 32;

  // Look-up field widths
  localparam int PORT_W  = 6;
  localparam int VLAN_W  = 8;
  localparam int DIDX_W  = 9;
  localparam int STA_W   = PORT_W + VLAN_W;
  localparam int DMAP_N  = 512;
  localparam int STP_N   = 16384;

  // Register byte offsets
  localparam logic [7:0] OFS_LEARN_Q  = 8'h00;
  localparam logic [7:0] OFS_TRUNC_EN = 8'h04;
  localparam logic [7:0] OFS_DENY_LO  = 8'h08;
  localparam logic [7:0] OFS_DENY_HI  = 8'h0c;
  localparam logic [7:0] OFS_BLK_LO   = 8'h10;
  localparam logic [7:0] OFS_BLK_HI   = 8'h14;
  localparam logic [7:0] OFS_LRN_LO   = 8'h18;
  localparam logic [7:0] OFS_LRN_HI   = 8'h1c;
  localparam logic [7:0] OFS_GLB_LO   = 8'h20;
  localparam logic [7:0] OFS_GLB_HI   = 8'h24;
  localparam logic [7:0] OFS_RXEN_LO  = 8'h28;
  localparam logic [7:0] OFS_RXEN_HI  = 8'h2c;
  localparam logic [7:0] OFS_DMAP_IDX = 8'h30;
  localparam logic [7:0] OFS_DMAP_LO  = 8'h34;
  localparam logic [7:0] OFS_DMAP_HI  = 8'h38;
  localparam logic [7:0] OFS_DMAP_CMD = 8'h3c;
  localparam logic [7:0] OFS_STP      = 8'h40;
  localparam logic [7:0] OFS_LRN_CNT  = 8'h44;

  // STP register fields
  localparam int STP_STATE_LSB = 0;
  localparam int STP_VLAN_LSB  = 8;
  localparam int STP_PORT_LSB  = 16;

  // Reset values
  localparam logic [MAP_W-1:0]     RST_MASK   = 58'h000_0000_0000_0000;
  localparam logic [MAP_W-1:0]     RST_GLOBAL = 58'h3ff_ffff_ffff_ffff;
  localparam logic [ETH_PORTS-1:0] RST_RXEN   = 50'h3_ffff_ffff_ffff;

  // Spanning tree state codes, listening folded into blocking
  typedef enum logic [1:0] {
    STP_BLOCKING   = 2'b00,
    STP_LEARNING   = 2'b01,
    STP_FORWARDING = 2'b10,
    STP_DISABLED   = 2'b11
  } l2bf_stp_t;

  // Look-up results presented per packet
  typedef struct packed {
    logic                valid;
    logic [PORT_W-1:0]   rx_port;
    logic [VLAN_W-1:0]   vlan_idx;
    logic                sa_hit;
    logic                sa_key;
    logic [1:0]          sa_permit;
    logic                da_hit;
    logic [DIDX_W-1:0]   da_map_idx;
    logic [MAP_W-1:0]    flood_map;
  } l2bf_req_t;

  // Filtered result per packet
  typedef struct packed {
    logic                valid;
    logic [MAP_W-1:0]    dest_map;
    logic                learn;
    logic                rx_drop;
    logic [QUEUES-1:0]   trunc;
  } l2bf_res_t;

endpackage

/* File: rtl/l2bf_stp_table.sv */
`timescale 1ns/100ps
// Port/VLAN spanning tree state table
module l2bf_stp_table
(
  input  wire logic                         mclk,
  input  wire logic                         wr_en,
  input  wire logic [l2bf_pkg::STA_W-1:0]   wr_addr,
  input  wire l2bf_pkg::l2bf_stp_t          wr_state,
  input  wire logic [l2bf_pkg::STA_W-1:0]   lk_addr,
  output l2bf_pkg::l2bf_stp_t               lk_state,
  input  wire logic [l2bf_pkg::STA_W-1:0]   sw_addr,
  output l2bf_pkg::l2bf_stp_t               sw_state
);

  // One 2-bit code per port/VLAN pair
  l2bf_pkg::l2bf_stp_t mem [l2bf_pkg::STP_N];

  // Write port and two registered read ports
  always_ff @(posedge mclk)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_state;
    end
    lk_state <= mem[lk_addr];
    sw_state <= mem[sw_addr];
  end

endmodule

/* File: rtl/l2bf_filter.sv */
`timescale 1ns/100ps
// Layer 2 bridging filter stage
module l2bf_filter
(
  input  wire logic                 mclk,
  input  wire logic                 rst,
  input  wire logic [7:0]           reg_addr,
  input  wire logic [31:0]          reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic [31:0]               reg_rdata,
  input  wire l2bf_pkg::l2bf_req_t  req_in,
  output l2bf_pkg::l2bf_res_t       res_out
);

  // Module state apart from the two tables and dmap_rd
  typedef struct packed {
    logic [2:0]                         learn_q;   // Learning queue select
    logic [l2bf_pkg::QUEUES-1:0]        trunc_en;  // Per-queue truncation
    logic [l2bf_pkg::MAP_W-1:0]         deny;      // Source-deny mask
    logic [l2bf_pkg::MAP_W-1:0]         blk;       // Blocking mask
    logic [l2bf_pkg::MAP_W-1:0]         lrn;       // Learning mask
    logic [l2bf_pkg::MAP_W-1:0]         glb;       // Global port mask
    logic [l2bf_pkg::ETH_PORTS-1:0]     rx_en;     // Per-port receive enable
    logic [l2bf_pkg::DIDX_W-1:0]        dmap_idx;  // Table write index
    logic [l2bf_pkg::MAP_W-1:0]         dmap_data; // Table write data
    logic [l2bf_pkg::STA_W-1:0]         stp_sel;   // Last STP address
    logic [31:0]                        lrn_cnt;   // Learning copies sent
    l2bf_pkg::l2bf_req_t                p1;        // Request in flight
    l2bf_pkg::l2bf_res_t                res;       // Registered result
    logic [31:0]                        rdata;     // Read answer
  } l2bf_state_t;

  l2bf_state_t s_reg;      // Current state
  l2bf_state_t s_next;     // Next state

  // Destination map table
  logic [l2bf_pkg::MAP_W-1:0] dmap_mem [l2bf_pkg::DMAP_N];
  logic [l2bf_pkg::MAP_W-1:0] dmap_rd;    // Read for stage 1
  logic                       dmap_we;    // Software table write
  logic                       stp_we;     // Software STP write
  logic [l2bf_pkg::STA_W-1:0] stp_waddr;  // STP write address
  l2bf_pkg::l2bf_stp_t        stp_wstate; // STP write code
  l2bf_pkg::l2bf_stp_t        stp_lk;     // Code for packet in stage 1
  l2bf_pkg::l2bf_stp_t        stp_sw;     // Code for software read
  logic                       rx_ok;      // Receive port enabled
  logic [l2bf_pkg::MAP_W-1:0] learn_bit;  // Learning queue bit

  // One-hot map bit for a supervisor queue
  function automatic logic [l2bf_pkg::MAP_W-1:0] queue_bit(input logic [2:0] q);
    logic [l2bf_pkg::MAP_W-1:0] v;
    v = '0;
    v[l2bf_pkg::QBASE + int'(q)] = 1'b1;
    return v;
  endfunction

  // Receive enable of an Ethernet port, zero for others
  function automatic logic port_enabled(input logic [l2bf_pkg::ETH_PORTS-1:0] en,
                                        input logic [l2bf_pkg::PORT_W-1:0]    p);
    logic r;
    r = 1'b0;
    if (int'(p) < l2bf_pkg::ETH_PORTS)
    begin
      r = en[p];
    end
    return r;
  endfunction

  // Software write strobes into the tables
  always_comb
  begin
    dmap_we    = reg_wr && (reg_addr == l2bf_pkg::OFS_DMAP_CMD) && reg_wdata[0];
    stp_we     = reg_wr && (reg_addr == l2bf_pkg::OFS_STP);
    stp_waddr  = {reg_wdata[l2bf_pkg::STP_PORT_LSB +: l2bf_pkg::PORT_W],
                  reg_wdata[l2bf_pkg::STP_VLAN_LSB +: l2bf_pkg::VLAN_W]};
    stp_wstate = l2bf_pkg::l2bf_stp_t'(reg_wdata[l2bf_pkg::STP_STATE_LSB +: 2]);
  end

  // Destination map table, read alongside request capture
  always_ff @(posedge mclk)
  begin
    if (dmap_we)
    begin
      dmap_mem[s_reg.dmap_idx] <= s_reg.dmap_data;
    end
    dmap_rd <= dmap_mem[req_in.da_map_idx];
  end

  // Spanning tree state table by port and VLAN
  l2bf_stp_table u_stp
  (
    .mclk     (mclk),
    .wr_en    (stp_we),
    .wr_addr  (stp_waddr),
    .wr_state (stp_wstate),
    .lk_addr  ({req_in.rx_port, req_in.vlan_idx}),
    .lk_state (stp_lk),
    .sw_addr  (s_reg.stp_sel),
    .sw_state (stp_sw)
  );

  // Helper terms for stage 2
  always_comb
  begin
    rx_ok     = port_enabled(s_reg.rx_en, s_reg.p1.rx_port);
    learn_bit = queue_bit(s_reg.learn_q);
  end

  // Next-state logic
  always_comb
  begin
    logic [l2bf_pkg::MAP_W-1:0] map;
    logic                       lrn;
    map    = '0;
    lrn    = 1'b0;
    s_next = s_reg;

    // Register writes
    if (reg_wr)
    begin
      unique case (reg_addr)
        l2bf_pkg::OFS_LEARN_Q:  s_next.learn_q  = reg_wdata[2:0];
        l2bf_pkg::OFS_TRUNC_EN: s_next.trunc_en = reg_wdata[l2bf_pkg::QUEUES-1:0];
        l2bf_pkg::OFS_DENY_LO:  s_next.deny[31:0] = reg_wdata;
        l2bf_pkg::OFS_DENY_HI:  s_next.deny[l2bf_pkg::MAP_W-1:32] = reg_wdata[l2bf_pkg::HI_W-1:0];
        l2bf_pkg::OFS_BLK_LO:   s_next.blk[31:0] = reg_wdata;
        l2bf_pkg::OFS_BLK_HI:   s_next.blk[l2bf_pkg::MAP_W-1:32] = reg_wdata[l2bf_pkg::HI_W-1:0];
        l2bf_pkg::OFS_LRN_LO:   s_next.lrn[31:0] = reg_wdata;
        l2bf_pkg::OFS_LRN_HI:   s_next.lrn[l2bf_pkg::MAP_W-1:32] = reg_wdata[l2bf_pkg::HI_W-1:0];
        l2bf_pkg::OFS_GLB_LO:   s_next.glb[31:0] = reg_wdata;
        l2bf_pkg::OFS_GLB_HI:   s_next.glb[l2bf_pkg::MAP_W-1:32] = reg_wdata[l2bf_pkg::HI_W-1:0];
        l2bf_pkg::OFS_RXEN_LO:  s_next.rx_en[31:0] = reg_wdata;
        l2bf_pkg::OFS_RXEN_HI:  s_next.rx_en[l2bf_pkg::ETH_PORTS-1:32] = reg_wdata[l2bf_pkg::RXHI_W-1:0];
        l2bf_pkg::OFS_DMAP_IDX: s_next.dmap_idx = reg_wdata[l2bf_pkg::DIDX_W-1:0];
        l2bf_pkg::OFS_DMAP_LO:  s_next.dmap_data[31:0] = reg_wdata;
        l2bf_pkg::OFS_DMAP_HI:  s_next.dmap_data[l2bf_pkg::MAP_W-1:32] = reg_wdata[l2bf_pkg::HI_W-1:0];
        l2bf_pkg::OFS_STP:      s_next.stp_sel = stp_waddr;
        default:                ;  // Unmapped, read-only counter or table command
      endcase
    end

    // Read answer, valid in the cycle after the strobe only
    s_next.rdata = 32'h0000_0000;
    if (reg_rd)
    begin
      unique case (reg_addr)
        l2bf_pkg::OFS_LEARN_Q:  s_next.rdata = {29'h0000_0000, s_reg.learn_q};
        l2bf_pkg::OFS_TRUNC_EN: s_next.rdata = {24'h00_0000, s_reg.trunc_en};
        l2bf_pkg::OFS_DENY_LO:  s_next.rdata = s_reg.deny[31:0];
        l2bf_pkg::OFS_DENY_HI:  s_next.rdata = {6'h00, s_reg.deny[l2bf_pkg::MAP_W-1:32]};
        l2bf_pkg::OFS_BLK_LO:   s_next.rdata = s_reg.blk[31:0];
        l2bf_pkg::OFS_BLK_HI:   s_next.rdata = {6'h00, s_reg.blk[l2bf_pkg::MAP_W-1:32]};
        l2bf_pkg::OFS_LRN_LO:   s_next.rdata = s_reg.lrn[31:0];
        l2bf_pkg::OFS_LRN_HI:   s_next.rdata = {6'h00, s_reg.lrn[l2bf_pkg::MAP_W-1:32]};
        l2bf_pkg::OFS_GLB_LO:   s_next.rdata = s_reg.glb[31:0];
        l2bf_pkg::OFS_GLB_HI:   s_next.rdata = {6'h00, s_reg.glb[l2bf_pkg::MAP_W-1:32]};
        l2bf_pkg::OFS_RXEN_LO:  s_next.rdata = s_reg.rx_en[31:0];
        l2bf_pkg::OFS_RXEN_HI:  s_next.rdata = {14'h0000, s_reg.rx_en[l2bf_pkg::ETH_PORTS-1:32]};
        l2bf_pkg::OFS_DMAP_IDX: s_next.rdata = {23'h00_0000, s_reg.dmap_idx};
        l2bf_pkg::OFS_DMAP_LO:  s_next.rdata = s_reg.dmap_data[31:0];
        l2bf_pkg::OFS_DMAP_HI:  s_next.rdata = {6'h00, s_reg.dmap_data[l2bf_pkg::MAP_W-1:32]};
        l2bf_pkg::OFS_STP:      s_next.rdata = {10'h000, s_reg.stp_sel[l2bf_pkg::STA_W-1:l2bf_pkg::VLAN_W],
                                                s_reg.stp_sel[l2bf_pkg::VLAN_W-1:0], 6'h00, stp_sw};
        l2bf_pkg::OFS_LRN_CNT:  s_next.rdata = s_reg.lrn_cnt;
        default:                s_next.rdata = 32'h0000_0000;  // Unmapped reads zero
      endcase
    end

    // Stage 1: capture request, tables read in parallel
    s_next.p1 = req_in;

    // Stage 2: initial map from destination key or flood map
    map = s_reg.p1.da_hit ? dmap_rd : s_reg.p1.flood_map;

    // Unknown source: copy to learning queue, never insert
    if (!s_reg.p1.sa_hit)
    begin
      map = map | learn_bit;
      lrn = 1'b1;
    end

    // Permit flag only meaningful on a source-address hit
    if (s_reg.p1.sa_hit && !s_reg.p1.sa_permit[s_reg.p1.sa_key])
    begin
      map = map & s_reg.deny;
    end

    // Spanning tree state masks, cumulative with the above
    unique case (stp_lk)
      l2bf_pkg::STP_DISABLED:   map = map & s_reg.deny;
      l2bf_pkg::STP_BLOCKING:   map = map & s_reg.blk;
      l2bf_pkg::STP_LEARNING:   map = map & s_reg.lrn;
      l2bf_pkg::STP_FORWARDING: map = map;
    endcase

    // Global transmit mask on every map
    map = map & s_reg.glb;

    // Disabled receive port drops everything
    s_next.res.rx_drop = 1'b0;
    if (!rx_ok)
    begin
      map                = '0;
      lrn                = 1'b0;
      s_next.res.rx_drop = s_reg.p1.valid;
    end

    // Result register
    s_next.res.valid    = s_reg.p1.valid;
    s_next.res.dest_map = s_reg.p1.valid ? map : '0;
    s_next.res.learn    = s_reg.p1.valid && lrn;
    s_next.res.trunc    = s_reg.p1.valid ? (s_reg.trunc_en & map[l2bf_pkg::MAP_W-1:l2bf_pkg::QBASE]) : '0;

    // Learning copy counter
    if (s_reg.p1.valid && lrn && |(map & learn_bit))
    begin
      s_next.lrn_cnt = s_reg.lrn_cnt + 32'h0000_0001;
    end
  end

  // State register
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      s_reg          <= '0;
      s_reg.deny     <= l2bf_pkg::RST_MASK;
      s_reg.blk      <= l2bf_pkg::RST_MASK;
      s_reg.lrn      <= l2bf_pkg::RST_MASK;
      s_reg.glb      <= l2bf_pkg::RST_GLOBAL;
      s_reg.rx_en    <= l2bf_pkg::RST_RXEN;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  // Outputs from flip-flops
  assign reg_rdata = s_reg.rdata;
  assign res_out   = s_reg.res;

  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  // Result follows request by two cycles
  property p_latency;
    req_in.valid |-> ##2 res_out.valid;
  endproperty
  a_latency: assert property (p_latency) else $error("result latency not two cycles");

  // Unknown source is flagged on an enabled port
  property p_learn_flag;
    s_reg.p1.valid && !s_reg.p1.sa_hit && rx_ok |=> res_out.learn;
  endproperty
  a_learn_flag: assert property (p_learn_flag) else $error("unknown source not flagged");

  // Learning copy reaches the selected queue when forwarding
  property p_learn_q;
    s_reg.p1.valid && !s_reg.p1.sa_hit && rx_ok && stp_lk == l2bf_pkg::STP_FORWARDING
      && |(learn_bit & s_reg.glb) |=> |(res_out.dest_map & $past(learn_bit));
  endproperty
  a_learn_q: assert property (p_learn_q) else $error("learning copy missing");

  // Truncation flags follow the queues reached
  property p_trunc;
    res_out.valid |-> res_out.trunc == ($past(s_reg.trunc_en) & res_out.dest_map[57:50]);
  endproperty
  a_trunc: assert property (p_trunc) else $error("truncation flags wrong");

  // Denied source stays within source-deny mask
  property p_deny;
    s_reg.p1.valid && s_reg.p1.sa_hit && !s_reg.p1.sa_permit[s_reg.p1.sa_key]
      |=> (res_out.dest_map & ~$past(s_reg.deny)) == '0;
  endproperty
  a_deny: assert property (p_deny) else $error("source deny mask not applied");

  // Disabled state within source-deny mask
  property p_disabled;
    s_reg.p1.valid && stp_lk == l2bf_pkg::STP_DISABLED |=> (res_out.dest_map & ~$past(s_reg.deny)) == '0;
  endproperty
  a_disabled: assert property (p_disabled) else $error("disabled state mask missing");

  // Blocking state within blocking mask
  property p_blocking;
    s_reg.p1.valid && stp_lk == l2bf_pkg::STP_BLOCKING |=> (res_out.dest_map & ~$past(s_reg.blk)) == '0;
  endproperty
  a_blocking: assert property (p_blocking) else $error("blocking mask missing");

  // Learning state within learning mask
  property p_learning;
    s_reg.p1.valid && stp_lk == l2bf_pkg::STP_LEARNING |=> (res_out.dest_map & ~$past(s_reg.lrn)) == '0;
  endproperty
  a_learning: assert property (p_learning) else $error("learning mask missing");

  // Forwarding with permitted known source keeps table map under global mask
  property p_forward;
    s_reg.p1.valid && s_reg.p1.da_hit && s_reg.p1.sa_hit && s_reg.p1.sa_permit[s_reg.p1.sa_key] && rx_ok
      && stp_lk == l2bf_pkg::STP_FORWARDING |=> res_out.dest_map == ($past(dmap_rd) & $past(s_reg.glb));
  endproperty
  a_forward: assert property (p_forward) else $error("forwarding map altered");

  // Disabled receive port drops packet
  property p_rx_off;
    s_reg.p1.valid && !rx_ok |=> res_out.rx_drop && res_out.dest_map == '0 && !res_out.learn;
  endproperty
  a_rx_off: assert property (p_rx_off) else $error("disabled port still receives");

  // No destination outside global mask
  property p_global;
    res_out.valid |-> (res_out.dest_map & ~$past(s_reg.glb)) == '0;
  endproperty
  a_global: assert property (p_global) else $error("global mask violated");

  // Scenarios of interest
  c_learn: cover property (res_out.valid && res_out.learn);
  c_deny: cover property (s_reg.p1.valid && s_reg.p1.sa_hit && !s_reg.p1.sa_permit[s_reg.p1.sa_key]);
  c_block: cover property (s_reg.p1.valid && stp_lk == l2bf_pkg::STP_BLOCKING);
  c_drop: cover property (res_out.rx_drop);

endmodule

/* File: verif/l2bf_lookup_model.sv */
`timescale 1ns/100ps
// Look-up pipeline stand-in, one request per send cycle
module l2bf_lookup_model
(
  input  wire logic                 mclk,
  input  wire logic                 rst,
  input  wire logic                 send,
  input  wire l2bf_pkg::l2bf_req_t  pkt,
  output l2bf_pkg::l2bf_req_t       req
);
  // Idle fields flip every cycle so stale data never looks like a request
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      req <= '0;
    end
    else if (send)
    begin
      req       <= pkt;
      req.valid <= 1'b1;
    end
    else
    begin
      req       <= ~req;
      req.valid <= 1'b0;
    end
  end
endmodule

/* File: verif/tb_l2bf_filter.sv */
`timescale 1ns/100ps
// Self-checking bench for the bridging filter stage
module tb_l2bf_filter;
  logic                 mclk;          // Core clock
  logic                 rst;           // Async reset
  logic [7:0]           reg_addr;      // Register address
  logic [31:0]          reg_wdata;     // Write data
  logic                 reg_wr;        // Write strobe
  logic                 reg_rd;        // Read strobe
  logic [31:0]          reg_rdata;     // Read data
  logic                 send;          // Request to look-up model
  l2bf_pkg::l2bf_req_t  pkt;           // Next request
  l2bf_pkg::l2bf_req_t  req_in;        // Request into filter
  l2bf_pkg::l2bf_res_t  res_out;       // Filter result
  l2bf_pkg::l2bf_res_t  ea = '0;       // Expectation pipeline
  l2bf_pkg::l2bf_res_t  eb = '0;
  logic [57:0]          msk [5];       // Shadow deny, block, learn, global, rx enable
  logic [57:0]          dm [512];      // Shadow destination maps
  logic [1:0]           st [16384];    // Shadow tree states
  logic [2:0]           lq;            // Shadow learning queue
  logic [7:0]           te;            // Shadow truncate enables
  logic [5:0]           pl [6] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h30, 6'h31};
  integer               seed;
  integer               n_fail;
  integer               num_checks;
  integer               lcnt;          // Expected learning copies

  l2bf_filter l2bf_filter_inst (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .req_in(req_in), .res_out(res_out));
  l2bf_lookup_model l2bf_lookup_model_inst (.mclk(mclk), .rst(rst), .send(send), .pkt(pkt), .req(req_in));

  // 50 MHz clock
  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // Expected result of one request
  function automatic l2bf_pkg::l2bf_res_t exp_f(l2bf_pkg::l2bf_req_t r);
    l2bf_pkg::l2bf_res_t e;
    logic [57:0]         m;
    e = '0;
    e.valid = 1'b1;
    m = r.da_hit ? dm[r.da_map_idx] : r.flood_map;
    e.learn = !r.sa_hit;
    if (!r.sa_hit) m[50 + lq] = 1'b1;
    if (r.sa_hit && !r.sa_permit[r.sa_key]) m = m & msk[0];
    case (st[{r.rx_port, r.vlan_idx}])
      2'h3: m = m & msk[0];
      2'h0: m = m & msk[1];
      2'h1: m = m & msk[2];
      default: m = m;
    endcase
    m = m & msk[3];
    if (r.rx_port >= 6'h32 || !msk[4][r.rx_port])
    begin
      m = '0;
      e.learn = 1'b0;
      e.rx_drop = 1'b1;
    end
    e.dest_map = m;
    e.trunc = te & m[57:50];
    return e;
  endfunction

  // Compare one result
  task chk_res(input l2bf_pkg::l2bf_res_t e, input l2bf_pkg::l2bf_res_t g);
    num_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("unexpected res_out exp %h got %h", e, g);
    end
  endtask

  // Compare one register read
  task chk_reg(input logic [7:0] a, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("unexpected reg %h exp %h got %h", a, e, g);
    end
  endtask

  // Register write cycle
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  // Register read cycle, data checked in the cycle after the strobe
  task rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    chk_reg(a, e, reg_rdata);
  endtask

  // Write a 58-bit mask as two words
  task wmask(input int k, input logic [57:0] v);
    wr(8'(8 + 8 * k), v[31:0]);
    wr(8'(12 + 8 * k), {6'h00, v[57:32]});
    msk[k] = v;
  endtask

  // Random request over the ports and VLANs with known states, or over port 6'h37 one time in 16
  task rnd_pkt(output l2bf_pkg::l2bf_req_t r);
    r = '0;
    r.rx_port = ($unsigned($random(seed)) % 16 == 0) ? 6'h37 : pl[$unsigned($random(seed)) % 6];
    r.vlan_idx = 8'($unsigned($random(seed)) % 4);
    {r.sa_hit, r.sa_key, r.sa_permit, r.da_hit} = 5'($random(seed));
    r.da_map_idx = 9'($unsigned($random(seed)) % 8);
    r.flood_map = 58'({$random(seed), $random(seed)});
  endtask

  // Run end and verdict
  task summarize;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Expectations follow each request two cycles deep
  always @(posedge mclk)
  begin
    ea <= req_in.valid ? exp_f(req_in) : '0;
    eb <= ea;
  end

  // Every cycle after reset the result must match, idle included
  always @(negedge mclk)
  begin
    if (!rst)
    begin
      chk_res(eb, res_out);
      if (eb.valid && eb.learn && eb.dest_map[50 + lq]) lcnt++;
    end
  end

  // Hang guard
  initial
  begin
    repeat (10000) @(posedge mclk);
    n_fail++;
    summarize;
  end

  // Main sequence
  initial
  begin
    l2bf_pkg::l2bf_req_t p;
    logic [1:0]          s;
    seed = 32'hda65;
    n_fail = 0;
    num_checks = 0;
    lcnt = 0;
    rst = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    send = 1'b0;
    pkt = '0;
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    rd(l2bf_pkg::OFS_LEARN_Q, 32'h0);
    rd(l2bf_pkg::OFS_GLB_LO, 32'hffffffff);
    rd(l2bf_pkg::OFS_GLB_HI, 32'h03ffffff);
    rd(l2bf_pkg::OFS_RXEN_HI, 32'h0003ffff);
    rd(l2bf_pkg::OFS_DENY_LO, 32'h0);
    rd(l2bf_pkg::OFS_LRN_CNT, 32'h0);
    rd(8'hfc, 32'h0);
    // Destination maps, entry 7 empty so a hit on it denies
    for (int i = 0; i < 8; i++)
    begin
      dm[i] = (i == 7) ? 58'h0 : 58'({$random(seed), $random(seed)});
      wr(l2bf_pkg::OFS_DMAP_IDX, i);
      wr(l2bf_pkg::OFS_DMAP_LO, dm[i][31:0]);
      wr(l2bf_pkg::OFS_DMAP_HI, {6'h00, dm[i][57:32]});
      wr(l2bf_pkg::OFS_DMAP_CMD, 32'h1);
    end
    rd(l2bf_pkg::OFS_DMAP_CMD, 32'h0);
    // All four state codes spread over port and VLAN pairs
    for (int i = 0; i < 6; i++)
      for (int v = 0; v < 4; v++)
      begin
        s = 2'(i + v);
        wr(l2bf_pkg::OFS_STP, {10'h000, pl[i], 8'(v), 6'h00, s});
        st[{pl[i], 8'(v)}] = s;
      end
    rd(l2bf_pkg::OFS_STP, {10'h000, pl[5], 8'h03, 6'h00, 2'h0});
    for (int r = 0; r < 3; r++)
    begin
      lq = 3'($random(seed));
      te = 8'($random(seed));
      wr(l2bf_pkg::OFS_LEARN_Q, {29'h0, lq});
      wr(l2bf_pkg::OFS_TRUNC_EN, {24'h0, te});
      wmask(0, 58'({$random(seed), $random(seed)}));
      // First round keeps the usual supervisor masks, later ones random
      wmask(1, (r == 0) ? 58'h200_0000_0000_0000 : 58'({$random(seed), $random(seed)}));
      wmask(2, (r == 0) ? (58'h200_0000_0000_0000 | (58'h1 << (50 + lq))) : 58'({$random(seed), $random(seed)}));
      wmask(3, ~(58'h1 << pl[$unsigned($random(seed)) % 6]));
      wmask(4, (r == 2) ? 58'h3_ffff_ffff_fffe : 58'h3_ffff_ffff_ffff);
      repeat (3) @(posedge mclk);
      for (int k = 0; k < 60; k++)
      begin
        rnd_pkt(p);
        if (k == 0) p.sa_hit = 1'b0;
        @(posedge mclk);
        send <= 1'b1;
        pkt <= p;
      end
      @(posedge mclk);
      send <= 1'b0;
      repeat (5) @(posedge mclk);
    end
    rd(l2bf_pkg::OFS_LRN_CNT, lcnt);
    summarize;
  end
endmodule
